// ### verilog/sps_pkg.sv
/*
 Shared constants and types for the split-port DDR SRAM port logic.
 Assumes nothing beyond a SystemVerilog compiler; imported by the FIFO and port design files.
*/
package sps_pkg;

   // ----------------------------------------------------------------
   // Organisation
   // ----------------------------------------------------------------
   localparam int BURST_LEN = 4;
   localparam int BEAT_W = 2;
   localparam int NIBBLE_W = 4;
   localparam int NIBBLE_LANES = 2;
   localparam int LANE9_W = 9;
   localparam int MAX_LANE9 = 4;
   localparam int DEF_DATA_W = 36;
   localparam int ADDR_W_X8 = 21;
   localparam int ADDR_W_X9 = 21;
   localparam int ADDR_W_X18 = 20;
   localparam int ADDR_W_X36 = 19;
   localparam int DEF_ADDR_W = ADDR_W_X36;
   localparam int WR_FIFO_DEPTH = 16;

   // ----------------------------------------------------------------
   // System clock
   // ----------------------------------------------------------------
   localparam int SYS_CLK_PERIOD_PS = 8000;

   // ----------------------------------------------------------------
   // Derived widths
   // ----------------------------------------------------------------
   function automatic int sps_addr_width(input int data_w);
      case (data_w)
         8: return ADDR_W_X8;
         9: return ADDR_W_X9;
         18: return ADDR_W_X18;
         36: return ADDR_W_X36;
         default: return 0;
      endcase
   endfunction

   function automatic int sps_lane9_count(input int data_w);
      return (data_w < LANE9_W) ? 1 : data_w / LANE9_W;
   endfunction

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   typedef enum logic {
      SPS_WR_IDLE,
      SPS_WR_BEATS
   } sps_wr_state_type;

   typedef enum logic [1:0] {
      SPS_RD_OFF,
      SPS_RD_BURST,
      SPS_RD_TAIL
   } sps_rd_state_type;

endpackage

// ### verilog/sps_fifo_if.sv
/*
 Valid/ready carrier for words passing between the port logic and its write buffer.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
interface sps_fifo_if #(
   parameter int W = 8
);
   logic valid;
   logic ready;
   logic [W-1:0] data;

   modport producer (output valid, output data, input ready);
   modport consumer (input valid, input data, output ready);
endinterface

// ### verilog/sps_wr_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides, width and depth set by parameters.
 Assumes one clock and a synchronous active-low reset; depth must be a power of two.
*/
`timescale 1ns/1ps
module sps_wr_fifo #(
   parameter int W = 8,
   parameter int DEPTH = sps_pkg::WR_FIFO_DEPTH
) (
   // System
   input wire logic sys_clk,
   input wire logic rst_b,
   // Fill side
   sps_fifo_if.consumer push,
   // Drain side
   sps_fifo_if.producer pop
);
   import sps_pkg::*;

   localparam int PTR_W = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PTR_W) != DEPTH) begin : g_depth_chk
      $error("FIFO depth must be a power of two, at least 2");
   end

   typedef struct packed {
      logic [PTR_W-1:0] wptr;
      logic [PTR_W-1:0] rptr;
      logic [PTR_W:0] count;
   } sps_fifo_state_type;

   sps_fifo_state_type st_reg, st_next;
   logic [W-1:0] store [DEPTH];
   logic do_push, do_pop;

   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   assign push.ready = (st_reg.count != (PTR_W+1)'(DEPTH));
   assign pop.valid = (st_reg.count != '0);
   assign pop.data = store[st_reg.rptr];
   assign do_push = push.valid && push.ready;
   assign do_pop = pop.valid && pop.ready;

   always_comb begin
      st_next = st_reg;
      if (do_push) begin
         st_next.wptr = st_reg.wptr + 1'b1;
      end
      if (do_pop) begin
         st_next.rptr = st_reg.rptr + 1'b1;
      end
      if (do_push && !do_pop) begin
         st_next.count = st_reg.count + 1'b1;
      end else if (do_pop && !do_push) begin
         st_next.count = st_reg.count - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Storage needs no reset; pointers guard every read
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         store[st_reg.wptr] <= push.data;
      end
   end
endmodule

// ### verilog/sps_port.sv
/*
 Port logic of a separate-read/separate-write double-data-rate SRAM, with its array.
 Assumes all pins come from outside the sys_clk domain and toggle well below its rate,
 so that every pin edge is seen as a level change after two synchroniser flops.
*/
// Operation
// - Write port select low at a true main clock rise starts a write.
// - Deselected write port ignores write data and leaves the array untouched.
// - Eight-bit organisation: two nibble masks cover bits 3:0 and 7:4, per beat.
// - A high nibble mask drops that nibble for the beat; stored nibble unchanged.
// - Nine-bit lane masks cover bits 8:0, 17:9, 26:18, 35:27, per data width.
// - Each lane mask is sampled on the same main clock edge as its beat.
// - Lanes with a high mask keep their stored contents.
// - One shared address bus, captured on true main clock rise for active accesses.
// - Address is 21, 20 or 19 bits by width; storage in one array of four-word groups.
// - Address is ignored on edges where the port's select is inactive.
// - Read data driven on output clock rises, or main clock in single clock mode.
// - Read data outputs go high impedance when the read port is unselected.
// - Read port select low at true main clock rise starts a read.
// - On deselect, finish the burst, then tri-state after next true output clock rise.
// - Each read returns four sequential words from the addressed group.
// - Accesses start only on true main clock rise, which captures synchronous inputs.
// - Complement main clock rise also captures data and masks; drives data in single mode.
// - Write data sampled on both main clock rises while a write is active.
`timescale 1ns/1ps
module sps_port #(
   parameter int DATA_W = sps_pkg::DEF_DATA_W,
   parameter int ADDR_W = sps_pkg::DEF_ADDR_W,
   parameter int ARRAY_ADDR_W = sps_pkg::DEF_ADDR_W,
   parameter int NINE_W = sps_pkg::MAX_LANE9
) (
   // System
   input wire logic sys_clk,
   input wire logic rst_b,
   // Clock pins
   input wire logic main_clk,
   input wire logic main_clk_n,
   input wire logic out_clk,
   input wire logic out_clk_n,
   input wire logic single_clock_mode,
   // Selects and address
   input wire logic write_port_select_n,
   input wire logic read_port_select_n,
   input wire logic [ADDR_W-1:0] addr,
   // Write data and masks
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [sps_pkg::NIBBLE_LANES-1:0] four_bit_lane_mask_n,
   input wire logic [NINE_W-1:0] nine_bit_lane_mask_n,
   // Read data
   output logic [DATA_W-1:0] rd_data,
   output logic rd_data_oe_n,
   // Status
   output logic write_buffer_ready
);
   import sps_pkg::*;

   // ----------------------------------------------------------------
   // Configuration checks
   // ----------------------------------------------------------------
   if (sps_addr_width(DATA_W) == 0) begin : g_width_chk
      $error("Data width must be 8, 9, 18 or 36");
   end
   if (ADDR_W != sps_addr_width(DATA_W)) begin : g_addr_chk
      $error("Address width does not match the data width");
   end
   if (ARRAY_ADDR_W < 1 || ARRAY_ADDR_W > ADDR_W) begin : g_array_chk
      $error("Array address width must lie between 1 and the address width");
   end
   if (NINE_W != sps_lane9_count(DATA_W)) begin : g_lane_chk
      $error("Nine-bit lane mask count does not match the data width");
   end

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   localparam int IDX_W = ARRAY_ADDR_W + BEAT_W;
   localparam int WORDS = BURST_LEN << ARRAY_ADDR_W;

   typedef struct packed {
      logic single_mode;
      logic k;
      logic k_n;
      logic c;
      logic c_n;
      logic wps_n;
      logic rps_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [NIBBLE_LANES-1:0] nib_n;
      logic [NINE_W-1:0] nine_n;
   } sps_pins_type;

   typedef struct packed {
      logic [IDX_W-1:0] idx;
      logic [DATA_W-1:0] data;
      logic [DATA_W-1:0] en;
   } sps_wr_entry_type;

   typedef struct packed {
      sps_pins_type pin_s1;
      sps_pins_type pin_s2;
      logic [3:0] clk_prev;
      sps_wr_state_type wr_state;
      logic [BEAT_W-1:0] wr_beat;
      logic wr_armed;
      logic [ADDR_W-1:0] wr_armed_addr;
      logic [ADDR_W-1:0] wr_addr;
      sps_rd_state_type rd_state;
      logic [BEAT_W-1:0] rd_beat;
      logic rd_pend;
      logic [ADDR_W-1:0] rd_pend_addr;
      logic [ADDR_W-1:0] rd_addr;
      logic [DATA_W-1:0] rd_data;
      logic rd_oe_n;
   } sps_port_state_type;

   localparam int ENTRY_W = $bits(sps_wr_entry_type);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a,
                                                    input logic [BEAT_W-1:0] beat);
      return {a[ARRAY_ADDR_W-1:0], beat};
   endfunction

   function automatic logic [DATA_W-1:0] lane_enables(input logic [NIBBLE_LANES-1:0] nib_n,
                                                       input logic [NINE_W-1:0] nine_n);
      logic [DATA_W-1:0] en;
      en = '0;
      for (int i = 0; i < DATA_W; i++) begin
         if (DATA_W == 8) begin
            en[i] = !nib_n[i / NIBBLE_W];
         end else begin
            en[i] = !nine_n[i / LANE9_W];
         end
      end
      return en;
   endfunction

   // ----------------------------------------------------------------
   // State and array
   // ----------------------------------------------------------------
   sps_port_state_type st_reg, st_next;
   logic [DATA_W-1:0] array_mem [WORDS];
   sps_wr_entry_type push_entry, pop_entry;
   logic push_valid;
   logic rd_emit;
   logic rise_k, rise_k_n, rise_oc, rise_oc_n;
   logic oc_now, oc_n_now;

   sps_fifo_if #(.W(ENTRY_W)) wr_push ();
   sps_fifo_if #(.W(ENTRY_W)) wr_pop ();

   // ----------------------------------------------------------------
   // Write buffer
   // ----------------------------------------------------------------
   // Beats arrive at pin pace; the buffer absorbs array stalls from read fetches
   sps_wr_fifo #(
      .W(ENTRY_W),
      .DEPTH(WR_FIFO_DEPTH)
   ) u_wr_fifo (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .push(wr_push.consumer),
      .pop(wr_pop.producer)
   );

   assign wr_push.valid = push_valid;
   assign wr_push.data = push_entry;
   assign pop_entry = wr_pop.data;
   // Array is single ported: a read beat takes it and the drain waits
   assign wr_pop.ready = !rd_emit;
   assign write_buffer_ready = wr_push.ready;

   // ----------------------------------------------------------------
   // Edge detection on synchronised clock pins
   // ----------------------------------------------------------------
   always_comb begin
      rise_k = st_reg.pin_s2.k && !st_reg.clk_prev[3];
      rise_k_n = st_reg.pin_s2.k_n && !st_reg.clk_prev[2];
      // Single clock mode moves the output timing onto the main pair
      oc_now = st_reg.pin_s2.single_mode ? st_reg.pin_s2.k : st_reg.pin_s2.c;
      oc_n_now = st_reg.pin_s2.single_mode ? st_reg.pin_s2.k_n : st_reg.pin_s2.c_n;
      rise_oc = oc_now && !st_reg.clk_prev[1];
      rise_oc_n = oc_n_now && !st_reg.clk_prev[0];
   end

   // ----------------------------------------------------------------
   // Sequencers
   // ----------------------------------------------------------------
   always_comb begin
      logic wr_take;
      logic start_now;
      wr_take = 1'b0;
      start_now = 1'b0;
      st_next = st_reg;
      push_valid = 1'b0;
      push_entry = '0;
      rd_emit = 1'b0;

      st_next.pin_s1 = {single_clock_mode, main_clk, main_clk_n, out_clk, out_clk_n,
                        write_port_select_n, read_port_select_n, addr, wr_data,
                        four_bit_lane_mask_n, nine_bit_lane_mask_n};
      st_next.pin_s2 = st_reg.pin_s1;
      st_next.clk_prev = {st_reg.pin_s2.k, st_reg.pin_s2.k_n, oc_now, oc_n_now};

      // Write side: beats on K, K#, K, K# after the select edge
      if (rise_k) begin
         if (st_reg.wr_state == SPS_WR_BEATS && st_reg.wr_beat == 2'd2) begin
            wr_take = 1'b1;
         end else if (st_reg.wr_armed) begin
            start_now = 1'b1;
            wr_take = 1'b1;
            st_next.wr_state = SPS_WR_BEATS;
            st_next.wr_addr = st_reg.wr_armed_addr;
            st_next.wr_armed = 1'b0;
         end
         // A select on a first-beat edge would collide with the armed burst
         if (!st_reg.pin_s2.wps_n && !start_now) begin
            st_next.wr_armed = 1'b1;
            st_next.wr_armed_addr = st_reg.pin_s2.addr;
         end
      end
      if (rise_k_n && st_reg.wr_state == SPS_WR_BEATS) begin
         wr_take = 1'b1;
      end
      if (wr_take) begin
         // Data is read only inside an active write burst
         push_valid = 1'b1;
         push_entry.idx = word_index(start_now ? st_reg.wr_armed_addr : st_reg.wr_addr,
                                     start_now ? 2'd0 : st_reg.wr_beat);
         push_entry.data = st_reg.pin_s2.data;
         push_entry.en = lane_enables(st_reg.pin_s2.nib_n, st_reg.pin_s2.nine_n);
         if (start_now) begin
            st_next.wr_beat = 2'd1;
         end else if (st_reg.wr_beat == 2'd3) begin
            st_next.wr_beat = 2'd0;
            st_next.wr_state = SPS_WR_IDLE;
         end else begin
            st_next.wr_beat = st_reg.wr_beat + 2'd1;
         end
      end

      // Read side: request capture on true main clock
      if (rise_k && !st_reg.pin_s2.rps_n) begin
         st_next.rd_pend = 1'b1;
         st_next.rd_pend_addr = st_reg.pin_s2.addr;
      end

      // Read side: beats on true and complement output clock rises
      if (rise_oc) begin
         if (st_reg.rd_state == SPS_RD_BURST && st_reg.rd_beat == 2'd2) begin
            rd_emit = 1'b1;
            st_next.rd_data = array_mem[word_index(st_reg.rd_addr, 2'd2)];
            st_next.rd_beat = 2'd3;
         end else if (st_reg.rd_state != SPS_RD_BURST && st_reg.rd_pend) begin
            rd_emit = 1'b1;
            st_next.rd_state = SPS_RD_BURST;
            st_next.rd_addr = st_reg.rd_pend_addr;
            st_next.rd_data = array_mem[word_index(st_reg.rd_pend_addr, 2'd0)];
            st_next.rd_beat = 2'd1;
            st_next.rd_oe_n = 1'b0;
            // A capture on this same cycle still wins over the clear
            st_next.rd_pend = rise_k && !st_reg.pin_s2.rps_n;
         end else if (st_reg.rd_state == SPS_RD_TAIL) begin
            st_next.rd_state = SPS_RD_OFF;
            st_next.rd_oe_n = 1'b1;
         end
      end else if (rise_oc_n && st_reg.rd_state == SPS_RD_BURST) begin
         rd_emit = 1'b1;
         st_next.rd_data = array_mem[word_index(st_reg.rd_addr, st_reg.rd_beat)];
         if (st_reg.rd_beat == 2'd3) begin
            // Last word stays driven until the next true output clock rise
            st_next.rd_state = SPS_RD_TAIL;
            st_next.rd_beat = 2'd0;
         end else begin
            st_next.rd_beat = st_reg.rd_beat + 2'd1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         st_reg <= '0;
         st_reg.pin_s1.wps_n <= 1'b1;
         st_reg.pin_s1.rps_n <= 1'b1;
         st_reg.pin_s2.wps_n <= 1'b1;
         st_reg.pin_s2.rps_n <= 1'b1;
         st_reg.wr_state <= SPS_WR_IDLE;
         st_reg.rd_state <= SPS_RD_OFF;
         st_reg.rd_oe_n <= 1'b1;
         // A clock pin already high at release still shows one rise once it reaches pin_s2
         st_reg.clk_prev <= 4'hF;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Array write from the buffer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (wr_pop.valid && wr_pop.ready) begin
         // Masked lanes keep what was stored
         array_mem[pop_entry.idx] <= (array_mem[pop_entry.idx] & ~pop_entry.en) |
                                     (pop_entry.data & pop_entry.en);
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data = st_reg.rd_data;
   assign rd_data_oe_n = st_reg.rd_oe_n;
endmodule

// ### testbench/sps_ctrl_model.sv
/*
 Memory controller model: drives both clock pairs, selects, address, data and lane masks.
 Assumes 16 sys_clk per main clock cycle; the bench queues half-cycle slots in pairs.
*/
`timescale 1ns/1ps
module sps_ctrl_model (
   // System
   input wire logic sys_clk,
   // Clock pins
   output logic main_clk,
   output logic main_clk_n,
   output logic out_clk,
   output logic out_clk_n,
   // Selects, address, data, masks
   output logic write_port_select_n,
   output logic read_port_select_n,
   output logic [sps_pkg::DEF_ADDR_W-1:0] addr,
   output logic [sps_pkg::DEF_DATA_W-1:0] wr_data,
   output logic [sps_pkg::MAX_LANE9-1:0] nine_bit_lane_mask_n
);
   import sps_pkg::*;
   typedef struct packed {
      logic w_n;
      logic r_n;
      logic [DEF_ADDR_W-1:0] a;
      logic [DEF_DATA_W-1:0] d;
      logic [MAX_LANE9-1:0] m;
   } sps_slot_type;
   sps_slot_type q[$];
   sps_slot_type pins, nxt;
   logic [3:0] ph;
   initial begin
      ph = 4'h0;
      pins = '1;
      nxt = '1;
   end
   // ----------------
   // Free-running clock pairs; output pair lags by a quarter cycle
   // ----------------
   assign main_clk = ~ph[3];
   assign main_clk_n = ph[3];
   assign out_clk = ph[3] ^ ph[2];
   assign out_clk_n = ~out_clk;
   assign {write_port_select_n, read_port_select_n, addr, wr_data, nine_bit_lane_mask_n} = pins;
   // Pins move mid-level, four sys_clk clear of every main clock rising edge
   always @(posedge sys_clk) begin
      ph <= ph + 4'h1;
      if (ph == 4'h3) begin
         pins <= nxt;
      end
      if (ph == 4'hB && q.size() > 1) begin
         pins <= q.pop_front();
         nxt <= q.pop_front();
      end else if (ph == 4'hB) begin
         // Deselected lines keep toggling so stale values never look valid
         pins <= {2'b11, ~pins.a, ~pins.d, ~pins.m};
         nxt <= {2'b11, pins.a, pins.d, pins.m};
      end
   end
   task automatic put(input logic w_n, input logic r_n, input logic [DEF_ADDR_W-1:0] a,
                      input logic [DEF_DATA_W-1:0] d, input logic [MAX_LANE9-1:0] m);
      q.push_back({w_n, r_n, a, d, m});
   endtask
   function automatic int pending();
      return q.size();
   endfunction
endmodule

// ### testbench/sps_port_assertions.sv
/*
 Port checker for sps_port, bound at the foot of this file.
 Assumes clock pins hold each level at least four sys_clk cycles.
*/
`timescale 1ns/1ps
module sps_port_assertions #(
   parameter int DATA_W = 36
) (
   // System
   input wire logic sys_clk,
   input wire logic rst_b,
   // Pins watched
   input wire logic main_clk,
   input wire logic main_clk_n,
   input wire logic out_clk,
   input wire logic out_clk_n,
   input wire logic single_clock_mode,
   input wire logic read_port_select_n,
   input wire logic [DATA_W-1:0] rd_data,
   input wire logic rd_data_oe_n,
   input wire logic write_buffer_ready
);
   // ----------------
   // Cycles since select and output clock rises
   // ----------------
   logic t_q, c_q;
   logic [7:0] idle_cnt, t_cnt, o_cnt;
   wire t_clk = single_clock_mode ? main_clk : out_clk;
   wire c_clk = single_clock_mode ? main_clk_n : out_clk_n;
   always_ff @(posedge sys_clk) begin
      t_q <= t_clk;
      c_q <= c_clk;
      if (!rst_b || !read_port_select_n) idle_cnt <= 8'h00;
      else if (idle_cnt != 8'hFF) idle_cnt <= idle_cnt + 8'h01;
      if (!rst_b || (t_clk && !t_q)) t_cnt <= 8'h00;
      else if (t_cnt != 8'hFF) t_cnt <= t_cnt + 8'h01;
      if (!rst_b || (t_clk && !t_q) || (c_clk && !c_q)) o_cnt <= 8'h00;
      else if (o_cnt != 8'hFF) o_cnt <= o_cnt + 8'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_reset_out;
      $rose(rst_b) |-> rd_data_oe_n && rd_data == '0;
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("read outputs not idle after reset");
   property p_reset_ready;
      $rose(rst_b) |-> write_buffer_ready;
   endproperty
   a_reset_ready: assert property (p_reset_ready) else $error("write buffer not ready after reset");
   property p_idle_tristate;
      idle_cnt > 8'h40 |-> rd_data_oe_n;
   endproperty
   a_idle_tristate: assert property (p_idle_tristate) else $error("outputs driven while unselected");
   property p_read_start;
      $rose(main_clk) && !read_port_select_n |-> ##[1:64] !rd_data_oe_n;
   endproperty
   a_read_start: assert property (p_read_start) else $error("read select did not start a burst");
   property p_start_cause;
      $fell(rd_data_oe_n) |-> idle_cnt <= 8'h28 && t_cnt >= 8'h01 && t_cnt <= 8'h05;
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("burst start without cause");
   property p_beat_edge;
      $changed(rd_data) |-> o_cnt >= 8'h01 && o_cnt <= 8'h05;
   endproperty
   a_beat_edge: assert property (p_beat_edge) else $error("read data moved off a clock rise");
   property p_tail;
      $rose(rd_data_oe_n) |-> t_cnt >= 8'h01 && t_cnt <= 8'h05;
   endproperty
   a_tail: assert property (p_tail) else $error("tri-state not on a true output rise");
   property p_burst_hold;
      $fell(rd_data_oe_n) |=> !rd_data_oe_n [*8];
   endproperty
   a_burst_hold: assert property (p_burst_hold) else $error("burst cut short");
endmodule
bind sps_port sps_port_assertions #(.DATA_W(DATA_W)) u_sps_port_assertions (.sys_clk, .rst_b, .main_clk,
   .main_clk_n, .out_clk, .out_clk_n, .single_clock_mode, .read_port_select_n, .rd_data, .rd_data_oe_n,
   .write_buffer_ready);

// ### testbench/tb_split_port_ddr_sram_port.sv
/*
 Self-checking bench: port logic behind a controller model, write buffer seen through the port.
 Assumes the model's pacing; read beats are sampled in the last sys_clk of each output clock level.
*/
`timescale 1ns/1ps
module tb_split_port_ddr_sram_port;
   import sps_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic single_clock_mode = 1'b0;
   logic main_clk, main_clk_n, out_clk, out_clk_n, write_port_select_n, read_port_select_n;
   logic [DEF_ADDR_W-1:0] addr;
   logic [DEF_DATA_W-1:0] wr_data, rd_data, mem [64], obs[$], exq[$];
   logic [MAX_LANE9-1:0] nine_bit_lane_mask_n;
   logic rd_data_oe_n, write_buffer_ready;
   logic last_oe_n = 1'b1;
   int failures = 0, n_checks = 0, cycles = 0;
   int ready_drops = 0;
   always #4 sys_clk = ~sys_clk;
   sps_ctrl_model u_sps_ctrl_model (.sys_clk, .main_clk, .main_clk_n, .out_clk, .out_clk_n,
      .write_port_select_n, .read_port_select_n, .addr, .wr_data, .nine_bit_lane_mask_n);
   // Small array depth keeps the reference memory tiny; upper address bits alias
   sps_port #(.ARRAY_ADDR_W(4)) u_sps_port (.sys_clk, .rst_b, .main_clk, .main_clk_n, .out_clk,
      .out_clk_n, .single_clock_mode, .write_port_select_n, .read_port_select_n, .addr, .wr_data,
      .four_bit_lane_mask_n(2'h3), .nine_bit_lane_mask_n, .rd_data, .rd_data_oe_n, .write_buffer_ready);
   // ----------------
   // Beat monitor and timeout
   // ----------------
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      // A low ready means beats would be lost
      if (rst_b && write_buffer_ready !== 1'b1) ready_drops <= ready_drops + 1;
      if (cycles == 20000) begin
         failures++;
         stop_test;
      end
      if (u_sps_ctrl_model.ph[2:0] == (single_clock_mode ? 3'h7 : 3'h3)) begin
         if (rd_data_oe_n === 1'b0) obs.push_back(rd_data);
         last_oe_n <= rd_data_oe_n;
      end
   end
   task automatic chk(input logic [35:0] seen, input logic [35:0] want);
      n_checks++;
      if (seen !== want) begin
         failures++;
         $display("FAIL t=%0t seen=%h expected=%h", $time, seen, want);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic settle;
      for (int i = 0; i < 2000 && u_sps_ctrl_model.pending() != 0; i++) @(posedge sys_clk);
      repeat (64) @(posedge sys_clk);
      chk(36'(obs.size()), 36'(exq.size()));
      while (obs.size() > 0 && exq.size() > 0) chk(obs.pop_front(), exq.pop_front());
      chk(36'(last_oe_n), 36'h1);
      obs.delete();
      exq.delete();
   endtask
   task automatic wr(input logic [3:0] g, input logic [35:0] b, input logic [15:0] m);
      logic [35:0] d;
      u_sps_ctrl_model.put(1'b0, 1'b1, 19'(g), ~b, 4'h0);
      u_sps_ctrl_model.put(1'b1, 1'b1, ~19'(g), b, 4'h0);
      for (int i = 0; i < 4; i++) begin
         d = b ^ {9{4'(i)}};
         u_sps_ctrl_model.put(1'b1, 1'b1, 19'h0, d, m[4*i+:4]);
         for (int l = 0; l < 4; l++)
            if (!m[4*i+l]) mem[{g, 2'(i)}][9*l+:9] = d[9*l+:9];
      end
   endtask
   task automatic rd(input logic [3:0] g);
      u_sps_ctrl_model.put(1'b1, 1'b0, 19'(g), 36'h0, 4'h0);
      for (int i = 0; i < 3; i++) u_sps_ctrl_model.put(1'b1, 1'b1, 19'h0, 36'h0, 4'h0);
      for (int i = 0; i < 4; i++) exq.push_back(mem[{g, 2'(i)}]);
   endtask
   // ----------------
   // Scenarios
   // ----------------
   task automatic t_write_read;
      wr(4'h1, 36'h123456789, 16'h0000);
      wr(4'h2, 36'h9ABCDEF01, 16'h0000);
      wr(4'h2, 36'h5A5A5A5A5, 16'h5A3C);
      settle;
      rd(4'h1);
      rd(4'h2);
      settle;
      $display("write_read done");
   endtask
   task automatic t_ignore;
      for (int i = 0; i < 8; i++) u_sps_ctrl_model.put(1'b1, 1'b1, 19'h1, 36'hFFFFFFFFF, 4'h0);
      settle;
      rd(4'h1);
      settle;
      $display("ignore done");
   endtask
   task automatic t_single;
      single_clock_mode <= 1'b1;
      repeat (16) @(posedge sys_clk);
      rd(4'h2);
      rd(4'h1);
      settle;
      single_clock_mode <= 1'b0;
      repeat (16) @(posedge sys_clk);
      $display("single done");
   endtask
   task automatic t_buffer;
      for (int g = 8; g < 12; g++) wr(4'(g), {4{9'(g * 41)}}, 16'h0000);
      for (int g = 8; g < 12; g++) wr(4'(g), {4{9'(g * 23)}}, 16'hA5C3 ^ 16'(g));
      settle;
      chk(36'(ready_drops), 36'h0);
      for (int g = 8; g < 12; g++) rd(4'(g));
      settle;
      chk(36'(ready_drops), 36'h0);
      chk(36'(write_buffer_ready), 36'h1);
      $display("buffer done");
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_write_read;
      t_ignore;
      t_single;
      t_buffer;
      stop_test;
   end
endmodule
